// >>> hw/clk_ctrl_consts.svh
/*
 Constants of the system clock control block: field widths, reset values and timing counts.
 Assumes inclusion by its bare name from the package and the design modules.
*/
`ifndef CLK_CTRL_CONSTS_SVH
`define CLK_CTRL_CONSTS_SVH

`define CC_DIV_W         8
`define CC_DIV_ONE       8'h00
`define CC_PLL_MUL_W     9
`define CC_PLL_DIV_W     6
`define CC_PLL_MUL_RST   9'h0C0
`define CC_PLL_DIV_RST   6'h10
`define CC_WAKE_LINES    16
`define CC_GAP_W         4
`define CC_SWITCH_GAP_NS 100
`define CC_CLK_PERIOD_NS 50
`define CC_SWITCH_GAP    4'((`CC_SWITCH_GAP_NS + `CC_CLK_PERIOD_NS - 1) / `CC_CLK_PERIOD_NS)
`define CC_GAP_ZERO      4'h0

`endif

// >>> hw/clk_ctrl_pkg.sv
/*
 Types shared by the clock control modules.
 Assumes clk_ctrl_consts.svh is on the include path.
*/
`include "clk_ctrl_consts.svh"

package clk_ctrl_pkg;
   typedef enum logic [1:0] {SRC_INT_FAST, SRC_EXT_FAST, SRC_MAIN_PLL} sys_src_t;
   typedef enum logic {REF_INT_FAST, REF_EXT_FAST} pll_ref_t;
   typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_STOP, MODE_STANDBY} pwr_mode_t;
   typedef enum logic [1:0] {SW_IDLE, SW_WAIT_READY, SW_GATED, SW_SWAPPED} sw_state_t;
endpackage

// >>> hw/div_if.sv
/*
 Carrier between the clock control top and one divider stage.
 Assumes a single sys_clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
`include "clk_ctrl_consts.svh"

interface div_if;
   logic                   tick_in;
   logic [`CC_DIV_W-1:0]   ratio;
   logic                   tick_out;
   modport ctrl (output tick_in, output ratio, input tick_out);
   modport stage (input tick_in, input ratio, output tick_out);
endinterface // div_if

`default_nettype wire

// >>> hw/tick_divider.sv
/*
 One divider stage: passes one tick out for every ratio+1 ticks in.
 Assumes tick_in is a one-cycle enable in the sys_clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
`include "clk_ctrl_consts.svh"

module tick_divider (
   input  wire logic sys_clk,
   input  wire logic reset,
   div_if.stage      dv
);
   logic [`CC_DIV_W-1:0] count_ff;
   logic                 wrap;

   assign wrap        = (count_ff >= dv.ratio);
   assign dv.tick_out = dv.tick_in & wrap;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         count_ff <= `CC_DIV_ONE;
      end else if (dv.tick_in) begin
         count_ff <= wrap ? `CC_DIV_ONE : count_ff + 1'b1;
      end
   end
endmodule // tick_divider

`default_nettype wire

// >>> hw/system_clock_control.sv
/*
 System clock control: source selection with glitch-free switch, failure fallback,
 bus clock enables, PLL configuration and low-power gating with wake sources.
 Assumes all inputs synchronous to sys_clk; sys_clk stands for the selected system clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "clk_ctrl_consts.svh"

// How it works
// RULE1 - system clock from three selectable sources
// RULE2 - main PLL reference: internal or external
// RULE3 - PLL multiply and divide factors programmable
// RULE4 - reset selects internal fast oscillator
// RULE5 - external failure forces internal oscillator automatically
// RULE6 - failure flag raises interrupt when enabled
// RULE7 - bus clock divided from system clock
// RULE8 - two peripheral clocks divided from bus
// RULE9 - software keeps bus frequencies under limits
// RULE10 - separate audio PLL, own configuration
// RULE11 - two fast and two slow sources
// RULE12 - sleep stops core clock only
// RULE13 - stop disables fast oscillators and PLL
// RULE14 - stop ends on lines, monitor, RTC, USB
// RULE15 - standby disables fast oscillators, RTC stays
// RULE16 - standby ends on reset, watchdog, pin, RTC
// RULE17 - glitch-free switch, status shows active source
module system_clock_control
   import clk_ctrl_pkg::*;
(
   input  wire logic                         sys_clk,
   input  wire logic                         reset,
   input  wire clk_ctrl_pkg::sys_src_t       src_req,
   input  wire clk_ctrl_pkg::pll_ref_t       pll_ref_req,
   input  wire logic [`CC_PLL_MUL_W-1:0]     pll_mul_req,
   input  wire logic [`CC_PLL_DIV_W-1:0]     pll_div_req,
   input  wire logic                         pll_en_req,
   input  wire logic [`CC_PLL_MUL_W-1:0]     audio_pll_mul_req,
   input  wire logic [`CC_PLL_DIV_W-1:0]     audio_pll_div_req,
   input  wire logic                         audio_pll_en_req,
   input  wire logic                         ext_osc_en_req,
   input  wire logic                         slow_xtal_en_req,
   input  wire logic                         slow_rc_en_req,
   input  wire logic [`CC_DIV_W-1:0]         hclk_div,
   input  wire logic [`CC_DIV_W-1:0]         apb1_div,
   input  wire logic [`CC_DIV_W-1:0]         apb2_div,
   input  wire logic                         int_osc_ready,
   input  wire logic                         ext_osc_ready,
   input  wire logic                         pll_locked,
   input  wire logic                         ext_osc_fail,
   input  wire logic                         fail_irq_en,
   input  wire logic                         fail_flag_clr,
   input  wire logic                         sleep_req,
   input  wire logic                         stop_req,
   input  wire logic                         standby_req,
   input  wire logic                         wake_irq,
   input  wire logic                         wake_event,
   input  wire logic [`CC_WAKE_LINES-1:0]    ext_wake_lines,
   input  wire logic                         supply_voltage_monitor,
   input  wire logic                         rtc_wake,
   input  wire logic                         usb_wake,
   input  wire logic                         external_reset_pin_n,
   input  wire logic                         independent_watchdog,
   input  wire logic                         wake_up_pin,
   output var  clk_ctrl_pkg::sys_src_t       sys_mux_sel,
   output var  clk_ctrl_pkg::sys_src_t       src_status,
   output logic                              sys_clk_gate,
   output logic                              switch_busy,
   output var  clk_ctrl_pkg::pll_ref_t       pll_ref_sel,
   output logic [`CC_PLL_MUL_W-1:0]          pll_mul,
   output logic [`CC_PLL_DIV_W-1:0]          pll_div,
   output logic [`CC_PLL_MUL_W-1:0]          audio_pll_mul,
   output logic [`CC_PLL_DIV_W-1:0]          audio_pll_div,
   output logic                              int_osc_en,
   output logic                              ext_osc_en,
   output logic                              pll_en,
   output logic                              audio_pll_en,
   output logic                              slow_xtal_en,
   output logic                              slow_rc_en,
   output logic                              fail_flag,
   output logic                              fail_irq,
   output logic                              core_clk_en,
   output logic                              hclk_tick,
   output logic                              apb1_tick,
   output logic                              apb2_tick,
   output var  clk_ctrl_pkg::pwr_mode_t      pwr_mode
);
   import clk_ctrl_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   sys_src_t                 mux_ff, status_ff, target_ff;
   sw_state_t                sw_ff, nxt_sw;
   pwr_mode_t                mode_ff, nxt_mode;
   pll_ref_t                 ref_ff;
   logic [`CC_GAP_W-1:0]     gap_ff;
   logic                     gate_ff, fail_ff, wkpin_ff;
   logic [`CC_PLL_MUL_W-1:0] mul_ff, amul_ff;
   logic [`CC_PLL_DIV_W-1:0] div_ff, adiv_ff;

   function automatic logic src_ready(input sys_src_t s);
      case (s)
         SRC_INT_FAST: src_ready = int_osc_ready;
         SRC_EXT_FAST: src_ready = ext_osc_ready & ~ext_osc_fail;
         SRC_MAIN_PLL: src_ready = pll_locked;
         default:      src_ready = 1'b0;
      endcase
   endfunction

   // ----------------------------------------
   // source request and failure fallback
   // ----------------------------------------
   logic     ext_in_use, fail_hit, awake, gap_done, src_differs;
   sys_src_t eff_req;

   assign ext_in_use  = (status_ff == SRC_EXT_FAST) |
                        ((status_ff == SRC_MAIN_PLL) & (ref_ff == REF_EXT_FAST));
   assign fail_hit    = ext_osc_fail & ext_in_use;
   assign eff_req     = (fail_ff | fail_hit) ? SRC_INT_FAST : src_req;   // see RULE5
   assign src_differs = (eff_req != status_ff);
   assign gap_done    = (gap_ff == `CC_GAP_ZERO);
   assign awake       = (mode_ff == MODE_RUN) | (mode_ff == MODE_SLEEP);

   // ----------------------------------------
   // glitch-free switch sequence
   // ----------------------------------------
   always_comb begin
      nxt_sw = sw_ff;
      case (sw_ff)
         SW_IDLE:       if (src_differs & awake) nxt_sw = SW_WAIT_READY;   // see RULE1
         SW_WAIT_READY: if (!src_differs) begin
                           nxt_sw = SW_IDLE;
                        end else if (src_ready(eff_req)) begin
                           nxt_sw = SW_GATED;                              // see RULE17
                        end
         SW_GATED:      if (gap_done) nxt_sw = SW_SWAPPED;
         SW_SWAPPED:    if (gap_done) nxt_sw = SW_IDLE;
         default:       nxt_sw = SW_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sw_ff     <= SW_IDLE;
         mux_ff    <= SRC_INT_FAST;                                          // see RULE4
         status_ff <= SRC_INT_FAST;
         target_ff <= SRC_INT_FAST;
         gate_ff   <= 1'b1;
         gap_ff    <= `CC_GAP_ZERO;
      end else if (!awake) begin
         sw_ff     <= SW_IDLE;
         mux_ff    <= SRC_INT_FAST;
         status_ff <= SRC_INT_FAST;
         gate_ff   <= 1'b1;
      end else begin
         sw_ff <= nxt_sw;
         if (sw_ff == SW_WAIT_READY && nxt_sw == SW_GATED) begin
            target_ff <= eff_req;
            gate_ff   <= 1'b0;
            gap_ff    <= `CC_SWITCH_GAP;
         end else if (sw_ff == SW_GATED && gap_done) begin
            mux_ff <= target_ff;                                             // see RULE17
            gap_ff <= `CC_SWITCH_GAP;
         end else if (sw_ff == SW_SWAPPED && gap_done) begin
            gate_ff   <= 1'b1;
            status_ff <= target_ff;                                          // see RULE17
         end else if (!gap_done) begin
            gap_ff <= gap_ff - 1'b1;
         end
      end
   end

   // ----------------------------------------
   // failure flag, pll settings, wake pin edge
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         fail_ff  <= 1'b0;
         ref_ff   <= REF_INT_FAST;
         mul_ff   <= `CC_PLL_MUL_RST;
         div_ff   <= `CC_PLL_DIV_RST;
         amul_ff  <= `CC_PLL_MUL_RST;
         adiv_ff  <= `CC_PLL_DIV_RST;
         wkpin_ff <= 1'b0;
      end else begin
         fail_ff  <= fail_hit | (fail_ff & ~fail_flag_clr);                  // see RULE5
         wkpin_ff <= wake_up_pin;
         if (!pll_en_req) begin
            ref_ff <= pll_ref_req;                                           // see RULE2
            mul_ff <= pll_mul_req;                                           // see RULE3
            div_ff <= pll_div_req;
         end
         if (!audio_pll_en_req) begin
            amul_ff <= audio_pll_mul_req;                                    // see RULE10
            adiv_ff <= audio_pll_div_req;
         end
      end
   end

   // ----------------------------------------
   // low-power modes
   // ----------------------------------------
   logic stop_wake, standby_wake;

   assign stop_wake    = (|ext_wake_lines) | supply_voltage_monitor | rtc_wake | usb_wake;   // see RULE14
   assign standby_wake = ~external_reset_pin_n | independent_watchdog |
                         (wake_up_pin & ~wkpin_ff) | rtc_wake;               // see RULE16

   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         MODE_RUN:     if (standby_req) nxt_mode = MODE_STANDBY;
                       else if (stop_req) nxt_mode = MODE_STOP;
                       else if (sleep_req) nxt_mode = MODE_SLEEP;
         MODE_SLEEP:   if (wake_irq | wake_event) nxt_mode = MODE_RUN;      // see RULE12
         MODE_STOP:    if (stop_wake) nxt_mode = MODE_RUN;
         MODE_STANDBY: if (standby_wake) nxt_mode = MODE_RUN;
         default:      nxt_mode = MODE_RUN;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mode_ff <= MODE_RUN;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // ----------------------------------------
   // bus clock dividers
   // ----------------------------------------
   div_if hdiv ();
   div_if p1div ();
   div_if p2div ();

   assign hdiv.tick_in  = gate_ff & awake;                                   // see RULE7
   assign hdiv.ratio    = hclk_div;
   assign p1div.tick_in = hdiv.tick_out;                                     // see RULE8
   assign p1div.ratio   = apb1_div;
   assign p2div.tick_in = hdiv.tick_out;
   assign p2div.ratio   = apb2_div;

   tick_divider u_hdiv  (.sys_clk(sys_clk), .reset(reset), .dv(hdiv));
   tick_divider u_p1div (.sys_clk(sys_clk), .reset(reset), .dv(p1div));
   tick_divider u_p2div (.sys_clk(sys_clk), .reset(reset), .dv(p2div));

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign sys_mux_sel   = mux_ff;
   assign src_status    = status_ff;
   assign sys_clk_gate  = gate_ff;
   assign switch_busy   = (sw_ff != SW_IDLE);
   assign pll_ref_sel   = ref_ff;
   assign pll_mul       = mul_ff;
   assign pll_div       = div_ff;
   assign audio_pll_mul = amul_ff;
   assign audio_pll_div = adiv_ff;
   assign int_osc_en    = awake;                                             // see RULE13 see RULE15
   assign ext_osc_en    = awake & ext_osc_en_req;                            // see RULE11
   assign pll_en        = awake & pll_en_req;
   assign audio_pll_en  = awake & audio_pll_en_req;
   assign slow_xtal_en  = slow_xtal_en_req;
   assign slow_rc_en    = slow_rc_en_req;
   assign fail_flag     = fail_ff;
   assign fail_irq      = fail_ff & fail_irq_en;                             // see RULE6
   assign core_clk_en   = gate_ff & (mode_ff == MODE_RUN);                   // see RULE12
   assign hclk_tick     = hdiv.tick_out;
   assign apb1_tick     = p1div.tick_out;
   assign apb2_tick     = p2div.tick_out;
   assign pwr_mode      = mode_ff;
endmodule // system_clock_control

`default_nettype wire

// >>> testbench/system_clock_control_checker.sv
/* Concurrent checks on the ports of system_clock_control.
   Assumes clk_ctrl_pkg is compiled first; bound to every design instance. */
`timescale 1ns/1ns
`default_nettype none
`include "clk_ctrl_consts.svh"
module system_clock_control_checker
   import clk_ctrl_pkg::*;
(
   input wire logic                      sys_clk,
   input wire logic                      reset,
   input wire clk_ctrl_pkg::sys_src_t    src_status,
   input wire clk_ctrl_pkg::sys_src_t    sys_mux_sel,
   input wire clk_ctrl_pkg::pll_ref_t    pll_ref_sel,
   input wire clk_ctrl_pkg::pwr_mode_t   pwr_mode,
   input wire logic                      sys_clk_gate,
   input wire logic                      ext_osc_fail,
   input wire logic                      fail_flag,
   input wire logic                      fail_irq,
   input wire logic                      fail_irq_en,
   input wire logic [`CC_DIV_W-1:0]      hclk_div,
   input wire logic                      hclk_tick,
   input wire logic                      apb1_tick,
   input wire logic                      core_clk_en,
   input wire logic                      int_osc_en,
   input wire logic                      ext_osc_en,
   input wire logic                      pll_en,
   input wire logic [`CC_WAKE_LINES-1:0] ext_wake_lines,
   input wire logic                      supply_voltage_monitor,
   input wire logic                      rtc_wake,
   input wire logic                      usb_wake,
   input wire logic                      external_reset_pin_n,
   input wire logic                      independent_watchdog,
   input wire logic                      wake_up_pin
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_reset_int_src: assert property ($fell(reset) |-> src_status == SRC_INT_FAST && pwr_mode == MODE_RUN)
      else $error("source not internal after reset");
   a_fail_sets_flag: assert property (ext_osc_fail && (src_status == SRC_EXT_FAST ||
      (src_status == SRC_MAIN_PLL && pll_ref_sel == REF_EXT_FAST)) |=> fail_flag) else $error("failure not flagged");
   a_fail_to_int: assert property (fail_flag && pwr_mode == MODE_RUN |-> ##[0:20] src_status == SRC_INT_FAST)
      else $error("no fallback to internal source");
   a_irq_follows_flag: assert property (fail_irq == (fail_flag && fail_irq_en))
      else $error("failure interrupt wrong");
   a_hclk_every_cycle: assert property (hclk_div == `CC_DIV_ONE && sys_clk_gate && $past(sys_clk_gate)
      && pwr_mode == MODE_RUN |-> hclk_tick) else $error("bus tick missing at ratio one");
   a_apb_on_hclk: assert property (apb1_tick |-> hclk_tick) else $error("peripheral tick without bus tick");
   a_sleep_core_off: assert property (pwr_mode == MODE_SLEEP |-> !core_clk_en) else $error("core clock on in sleep");
   a_stop_osc_off: assert property (pwr_mode == MODE_STOP |-> !int_osc_en && !ext_osc_en && !pll_en)
      else $error("oscillator on in stop");
   a_stop_wake_run: assert property (pwr_mode == MODE_STOP && (|ext_wake_lines || supply_voltage_monitor
      || rtc_wake || usb_wake) |=> pwr_mode == MODE_RUN) else $error("stop not left on wake source");
   a_standby_osc_off: assert property (pwr_mode == MODE_STANDBY |-> !int_osc_en && !ext_osc_en)
      else $error("oscillator on in standby");
   a_standby_wake_run: assert property (pwr_mode == MODE_STANDBY && (!external_reset_pin_n || independent_watchdog
      || $rose(wake_up_pin) || rtc_wake) |=> pwr_mode == MODE_RUN) else $error("standby not left on wake source");
   a_mux_when_gated: assert property ($changed(sys_mux_sel) && $past(pwr_mode) == MODE_RUN && pwr_mode == MODE_RUN
      |-> !sys_clk_gate) else $error("mux changed while clock ungated");
   c_pll_used: cover property (src_status == SRC_MAIN_PLL);
   c_fail_irq: cover property (fail_irq);
   c_standby: cover property (pwr_mode == MODE_STANDBY);
endmodule // system_clock_control_checker
bind system_clock_control system_clock_control_checker system_clock_control_checker_inst (.*);
`default_nettype wire

// >>> testbench/system_clock_control_bench.sv
/* Self-checking bench for system_clock_control.
   Assumes the package, the design and the checker are compiled before it. */
`timescale 1ns/1ns
`default_nettype none
`include "clk_ctrl_consts.svh"
module system_clock_control_bench;
   import clk_ctrl_pkg::*;
   sys_src_t   src_req, sys_mux_sel, src_status;
   pll_ref_t   pll_ref_req, pll_ref_sel;
   pwr_mode_t  pwr_mode;
   logic [8:0] pll_mul_req, audio_pll_mul_req, pll_mul, audio_pll_mul;
   logic [5:0] pll_div_req, audio_pll_div_req, pll_div, audio_pll_div;
   logic [7:0] hclk_div, apb1_div, apb2_div;
   logic [15:0] ext_wake_lines;
   logic sys_clk, reset, pll_en_req, audio_pll_en_req, ext_osc_en_req, slow_xtal_en_req, slow_rc_en_req;
   logic int_osc_ready, ext_osc_ready, pll_locked, ext_osc_fail, fail_irq_en, fail_flag_clr, sleep_req, stop_req;
   logic standby_req, wake_irq, wake_event, supply_voltage_monitor, rtc_wake, usb_wake, external_reset_pin_n;
   logic independent_watchdog, wake_up_pin, sys_clk_gate, switch_busy, int_osc_en, ext_osc_en, pll_en;
   logic audio_pll_en, slow_xtal_en, slow_rc_en, fail_flag, fail_irq, core_clk_en, hclk_tick, apb1_tick, apb2_tick;
   int fails = 0, comparisons = 0, cyc = 0;
   system_clock_control system_clock_control_inst (.*);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         end_sim();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wait_src(input sys_src_t s);
      int   i;
      logic busy_seen;
      i = 0;
      busy_seen = 1'b0;
      while (src_status !== s && i < 40) begin
         @(negedge sys_clk);
         busy_seen |= (switch_busy === 1'b1);
         i++;
      end
      chk(src_status, s);
      chk({sys_mux_sel, sys_clk_gate}, {s, 1'b1});
      chk({switch_busy, busy_seen}, {1'b0, (i > 0)});
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      @(negedge sys_clk);
      chk({src_status, sys_mux_sel, pwr_mode, fail_flag}, {SRC_INT_FAST, SRC_INT_FAST, MODE_RUN, 1'b0});
      chk({pll_mul, pll_div, pll_ref_sel}, {9'h0C0, 6'h10, REF_INT_FAST});
   endtask
   task automatic t_switch;
      @(posedge sys_clk);
      pll_ref_req <= REF_EXT_FAST;
      pll_mul_req <= 9'h150;
      pll_div_req <= 6'h08;
      audio_pll_mul_req <= 9'h0C3;
      audio_pll_div_req <= 6'h05;
      slow_xtal_en_req <= 1'b1;
      src_req <= SRC_EXT_FAST;
      wait_src(SRC_EXT_FAST);
      @(posedge sys_clk);
      pll_en_req <= 1'b1;
      audio_pll_en_req <= 1'b1;
      @(posedge sys_clk);
      pll_mul_req <= 9'h001; // must not reach a running pll
      audio_pll_mul_req <= 9'h001;
      repeat (2) @(negedge sys_clk);
      chk({pll_ref_sel, pll_mul, pll_div}, {REF_EXT_FAST, 9'h150, 6'h08});
      chk({audio_pll_mul, audio_pll_div, audio_pll_en}, {9'h0C3, 6'h05, 1'b1});
      chk({slow_xtal_en, slow_rc_en, pll_en, ext_osc_en, int_osc_en}, 5'b10111);
      @(posedge sys_clk);
      src_req <= SRC_MAIN_PLL;
      wait_src(SRC_MAIN_PLL);
   endtask
   task automatic t_fail;
      @(posedge sys_clk);
      fail_irq_en <= 1'b1;
      ext_osc_fail <= 1'b1;
      @(posedge sys_clk);
      ext_osc_fail <= 1'b0;
      @(negedge sys_clk);
      chk({fail_flag, fail_irq}, 2'b11);
      wait_src(SRC_INT_FAST);
      @(posedge sys_clk);
      fail_irq_en <= 1'b0;
      src_req <= SRC_INT_FAST;
      @(negedge sys_clk);
      chk({fail_flag, fail_irq}, 2'b10);
      @(posedge sys_clk);
      fail_flag_clr <= 1'b1;
      @(posedge sys_clk);
      fail_flag_clr <= 1'b0;
      @(negedge sys_clk);
      chk(fail_flag, 1'b0);
   endtask
   task automatic t_div;
      int h, a1, a2;
      h = 0;
      a1 = 0;
      a2 = 0;
      @(posedge sys_clk);
      hclk_div <= 8'h01;
      apb1_div <= 8'h01;
      repeat (8) @(posedge sys_clk);
      repeat (40) begin
         @(negedge sys_clk);
         h += (hclk_tick === 1'b1);
         a1 += (apb1_tick === 1'b1);
         a2 += (apb2_tick === 1'b1);
      end
      chk(h, 20);
      chk({a1[7:0], a2[7:0]}, {8'h0A, 8'h14});
      @(posedge sys_clk);
      hclk_div <= 8'h00;
      apb1_div <= 8'h00;
   endtask
   task automatic t_lp(input pwr_mode_t m, input int w);
      @(posedge sys_clk);
      sleep_req <= (m == MODE_SLEEP);
      stop_req <= (m == MODE_STOP);
      standby_req <= (m == MODE_STANDBY);
      @(posedge sys_clk);
      {sleep_req, stop_req, standby_req} <= 3'b000;
      @(negedge sys_clk);
      chk(pwr_mode, m);
      if (m == MODE_SLEEP) chk({core_clk_en, hclk_tick, int_osc_en}, 3'b011);
      else chk({int_osc_en, ext_osc_en, pll_en & (m == MODE_STOP)}, 3'b000);
      @(posedge sys_clk);
      case (w)
         0: wake_irq <= 1'b1;
         1: wake_event <= 1'b1;
         2: ext_wake_lines <= 16'h8000;
         3: supply_voltage_monitor <= 1'b1;
         4: rtc_wake <= 1'b1;
         5: usb_wake <= 1'b1;
         6: external_reset_pin_n <= 1'b0;
         7: independent_watchdog <= 1'b1;
         default: wake_up_pin <= 1'b1;
      endcase
      @(posedge sys_clk);
      {wake_irq, wake_event, supply_voltage_monitor, rtc_wake, usb_wake, independent_watchdog, wake_up_pin} <= '0;
      ext_wake_lines <= 16'h0000;
      external_reset_pin_n <= 1'b1;
      @(negedge sys_clk);
      chk({pwr_mode, core_clk_en}, {MODE_RUN, 1'b1});
   endtask
   initial begin
      {pll_en_req, audio_pll_en_req, slow_xtal_en_req, slow_rc_en_req, ext_osc_fail, fail_irq_en} = '0;
      {fail_flag_clr, sleep_req, stop_req, standby_req, wake_irq, wake_event, supply_voltage_monitor} = '0;
      {rtc_wake, usb_wake, independent_watchdog, wake_up_pin, hclk_div, apb1_div, apb2_div, ext_wake_lines} = '0;
      {int_osc_ready, ext_osc_ready, pll_locked, ext_osc_en_req, external_reset_pin_n, reset} = '1;
      {pll_mul_req, pll_div_req, audio_pll_mul_req, audio_pll_div_req} = '0;
      src_req = SRC_INT_FAST;
      pll_ref_req = REF_INT_FAST;
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_switch();
      t_fail();
      t_div();
      for (int w = 0; w < 9; w++) t_lp((w < 2) ? MODE_SLEEP : (w < 6) ? MODE_STOP : MODE_STANDBY, w);
      t_lp(MODE_STANDBY, 4);
      @(posedge sys_clk);
      src_req <= SRC_EXT_FAST;
      wait_src(SRC_EXT_FAST);
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      end_sim();
   end
endmodule // system_clock_control_bench
`default_nettype wire
